// *** rtl/flag_edge_catch.sv ***
`timescale 1ns/1ps

// sticky catch of a rising edge on one flag; set beats clear
module flag_edge_catch
    import irq_bridge_pkg::*;
(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_nrst,
    // flag and clear
    input  wire logic i_flag,
    input  wire logic i_clr,
    // sticky result
    output logic      o_caught
);

    logic flag_d_ff;
    logic caught_ff;
    logic rise;

    assign rise     = i_flag & ~flag_d_ff;
    assign o_caught = caught_ff;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            flag_d_ff <= 1'b0;
        else
            flag_d_ff <= i_flag;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            caught_ff <= 1'b0;
        else if (rise)
            caught_ff <= 1'b1;
        else if (i_clr)
            caught_ff <= 1'b0;
    end

endmodule // flag_edge_catch

// *** rtl/irq_bridge_pkg.sv ***
package irq_bridge_pkg;

    // register bus
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam logic [7:0]  OFS_STATUS      = 8'h00;
    localparam logic [7:0]  OFS_ENABLE      = 8'h04;
    localparam logic [7:0]  OFS_EVENT       = 8'h08;

    // reset values
    localparam logic [31:0] RST_ENABLE      = 32'h0000_0000;
    localparam logic [31:0] RST_EVENT       = 32'h0000_0000;

    // enable bits that exist: 29,28,25,24,23..17,10,9,8
    localparam logic [31:0] ENABLE_MASK     = 32'h33fe_0700;

    // mirrored status bits: 10:9 and 7:0
    localparam logic [31:0] MIRROR_MASK     = 32'h0000_06ff;

    // mirrored field positions
    localparam int          BIT_SETUP       = 0;
    localparam int          BIT_STATUS_NAK  = 1;
    localparam int          BIT_STATUS      = 2;
    localparam int          BIT_RX_ZERO     = 3;
    localparam int          BIT_SOF         = 4;
    localparam int          BIT_EP0         = 5;
    localparam int          BIT_EP          = 6;
    localparam int          BIT_NAK         = 7;
    localparam int          BIT_USB_RST     = 9;
    localparam int          BIT_USB_RST_END = 10;

endpackage : irq_bridge_pkg

// *** rtl/usb_core_irq_status_enable.sv ***
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

// Operation
// R1: status bit 7 live read-only copy of core nak flag, cleared only in core
// R2: status bit 6 live read-only copy of core endpoint flag
// R3: status bit 3 live read-only copy of core zero-length receive flag
// R4: bits 5,4,2,1,0 copy endpoint-0, sof, status, status-nak, setup flags
// R5: bits 10:9 and 7:0 wired straight to core flags, no latching
// R6: writes to mirrored status bits change nothing
// R7: each enable bit gates its status source onto the interrupt request
// R8: bit 9 shows core bus reset asserted, bit 10 shows it deasserted
module usb_core_irq_status_enable
    import irq_bridge_pkg::*;
(
    // clock and reset
    input  wire logic              i_sys_clk,
    input  wire logic              i_nrst,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wr_data,
    input  wire logic              i_wr_en,
    input  wire logic              i_rd_en,
    output logic      [DATA_W-1:0] o_rd_data,
    // usb_device_core flag outputs
    input  wire logic              i_core_setup,
    input  wire logic              i_core_status_nak,
    input  wire logic              i_core_status,
    input  wire logic              i_core_rx_zero,
    input  wire logic              i_core_sof,
    input  wire logic              i_core_ep0,
    input  wire logic              i_core_ep,
    input  wire logic              i_core_nak,
    input  wire logic              i_core_usb_reset,
    input  wire logic              i_core_usb_reset_end,
    // interrupt request
    output logic                   o_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // one entry per register the port can reach
    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_STATUS,
        SEL_ENABLE,
        SEL_EVENT
    } reg_sel_t;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // exact match only, so no register shows up again higher in the map
    function automatic reg_sel_t reg_select(input logic [ADDR_W-1:0] a);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (hit(a, OFS_STATUS))
        begin
            sel = SEL_STATUS;
        end
        else if (hit(a, OFS_ENABLE))
        begin
            sel = SEL_ENABLE;
        end
        else if (hit(a, OFS_EVENT))
        begin
            sel = SEL_EVENT;
        end
        reg_select = sel;
    endfunction

    // status word and stored registers
    logic [DATA_W-1:0] live_status;
    logic [DATA_W-1:0] enable_ff;
    logic [DATA_W-1:0] event_q;
    // read path
    logic [DATA_W-1:0] rd_data_ff;
    logic [DATA_W-1:0] nxt_rd_data;
    // interrupt path
    logic [DATA_W-1:0] pend_src;
    logic [DATA_W-1:0] irq_src;
    logic              irq_ff;
    logic              nxt_irq;
    // access strobes, one cycle each
    reg_sel_t          access_sel;
    logic              wr_enable_hit;
    logic              event_clr;

    assign access_sel    = reg_select(i_addr);
    assign wr_enable_hit = i_wr_en && (access_sel == SEL_ENABLE);

    ////////////////////////////////////////////////////////////////////////////
    // mirrored status: combinational from core, no storage
    // bit 8 and bits 29:17 belong to bridge sources not built here and read 0;
    // a read is registered once, so software sees the flags one cycle late

    always_comb
    begin
        live_status                  = '0;
        live_status[BIT_NAK]         = i_core_nak;           // R1 R5
        live_status[BIT_EP]          = i_core_ep;            // R2 R5
        live_status[BIT_RX_ZERO]     = i_core_rx_zero;       // R3 R5
        live_status[BIT_EP0]         = i_core_ep0;           // R4
        live_status[BIT_SOF]         = i_core_sof;           // R4
        live_status[BIT_STATUS]      = i_core_status;        // R4
        live_status[BIT_STATUS_NAK]  = i_core_status_nak;    // R4
        live_status[BIT_SETUP]       = i_core_setup;         // R4
        live_status[BIT_USB_RST]     = i_core_usb_reset;     // R8 R5
        live_status[BIT_USB_RST_END] = i_core_usb_reset_end; // R8 R5
    end

    ////////////////////////////////////////////////////////////////////////////
    // enable register; status and event offsets take no write at all

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            enable_ff <= RST_ENABLE;
        end
        else if (wr_enable_hit)
        begin
            // bits with no source built here still store, so software can probe them
            enable_ff <= i_wr_data & ENABLE_MASK; // R7
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky edge catch so short core pulses are not missed by software

    // clear rides on the read itself, so the word returned is the word cleared;
    // an edge landing in that same cycle stays set for the next read
    assign event_clr = i_rd_en && (access_sel == SEL_EVENT);

    genvar g;
    generate
        for (g = 0; g < DATA_W; g++)
        begin : g_evt
            if (MIRROR_MASK[g])
            begin : g_on
                flag_edge_catch u_catch (
                    .i_sys_clk (i_sys_clk),
                    .i_nrst    (i_nrst),
                    .i_flag    (live_status[g]),
                    .i_clr     (event_clr),
                    .o_caught  (event_q[g])
                );
            end
            else
            begin : g_off
                // no edge catch where there is no core flag to watch
                assign event_q[g] = RST_EVENT[g];
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe, zero otherwise

    always_comb
    begin
        nxt_rd_data = '0;
        if (i_rd_en)
        begin
            case (access_sel)
                SEL_STATUS:
                begin
                    // mirrored bits come from the core only, never from a write
                    nxt_rd_data = live_status; // R5 R6
                end
                SEL_ENABLE:
                begin
                    nxt_rd_data = enable_ff; // R7
                end
                SEL_EVENT:
                begin
                    nxt_rd_data = event_q;
                end
                default:
                begin
                    // unmapped offsets read as zero
                    nxt_rd_data = '0;
                end
            endcase
        end
    end

    // back to zero after one cycle, so an idle port reads nothing
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            rd_data_ff <= '0;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: registered, so one cycle behind the sources

    // a source counts while its live flag or its caught edge is set
    assign pend_src = live_status | event_q;
    assign irq_src  = pend_src & enable_ff; // R7
    assign nxt_irq  = |irq_src;

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_ff <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, each straight from its flip-flop

    assign o_rd_data = rd_data_ff;
    assign o_irq     = irq_ff;

endmodule // usb_core_irq_status_enable

// *** verification/core_flag_model.sv ***
`timescale 1ns/1ps
module core_flag_model
(
    input  wire logic       i_sys_clk,
    input  wire logic [9:0] i_cmd,
    output logic      [9:0] o_flags
);
    // registered, as real core flags only move on a clock edge
    always_ff @(posedge i_sys_clk)
    begin
        o_flags <= i_cmd;
    end
endmodule // core_flag_model

// *** verification/irq_status_monitor.sv ***
`timescale 1ns/1ps
module irq_status_monitor
    import irq_bridge_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_nrst,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic        i_wr_en,
    input wire logic        i_rd_en,
    input wire logic [31:0] o_rd_data,
    input wire logic        i_core_setup,
    input wire logic        i_core_status_nak,
    input wire logic        i_core_status,
    input wire logic        i_core_rx_zero,
    input wire logic        i_core_sof,
    input wire logic        i_core_ep0,
    input wire logic        i_core_ep,
    input wire logic        i_core_nak,
    input wire logic        i_core_usb_reset,
    input wire logic        i_core_usb_reset_end,
    input wire logic        o_irq
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    wire logic rs = i_rd_en && i_addr == OFS_STATUS;
    wire logic [31:0] live = {21'h0, i_core_usb_reset_end, i_core_usb_reset, 1'b0, i_core_nak,
        i_core_ep, i_core_ep0, i_core_sof, i_core_rx_zero, i_core_status, i_core_status_nak,
        i_core_setup};
    a_nak_copy: assert property (rs |=> o_rd_data[7] == $past(live[7]))
        else $error("nak bit");
    a_ep_copy: assert property (rs |=> o_rd_data[6] == $past(live[6]))
        else $error("ep bit");
    a_rx_zero_copy: assert property (rs |=> o_rd_data[3] == $past(live[3]))
        else $error("rx zero bit");
    a_core_flags: assert property (rs |=> o_rd_data[5:0] == $past(live[5:0]))
        else $error("core flag bits");
    a_bus_reset: assert property (rs |=> o_rd_data[10:9] == $past(live[10:9]))
        else $error("bus reset bits");
    a_live_word: assert property (rs |=> o_rd_data == $past(live))
        else $error("status word");
    a_data_idle: assert property (!i_rd_en |=> o_rd_data == 32'h0)
        else $error("idle data");
    a_wr_ignored: assert property (i_wr_en && i_addr == OFS_STATUS ##[1:2] rs
        |=> o_rd_data == $past(live)) else $error("status written");
endmodule // irq_status_monitor

bind usb_core_irq_status_enable irq_status_monitor mon (.*);

// *** verification/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import irq_bridge_pkg::*;
    logic        i_sys_clk, i_nrst, i_wr_en, i_rd_en, o_irq;
    logic [7:0]  i_addr;
    logic [31:0] i_wr_data, o_rd_data, d;
    logic [9:0]  cmd, fl;
    int          miscompares, samples_checked;
    core_flag_model core (.i_sys_clk(i_sys_clk), .i_cmd(cmd), .o_flags(fl));
    usb_core_irq_status_enable DUT (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
        .i_core_setup(fl[0]), .i_core_status_nak(fl[1]), .i_core_status(fl[2]),
        .i_core_rx_zero(fl[3]), .i_core_sof(fl[4]), .i_core_ep0(fl[5]), .i_core_ep(fl[6]),
        .i_core_nak(fl[7]), .i_core_usb_reset(fl[8]), .i_core_usb_reset_end(fl[9]),
        .o_irq(o_irq));
    initial
    begin
        i_sys_clk = 1'b0;
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge i_sys_clk);
        i_wr_en <= 1'b1;
        i_addr <= a;
        i_wr_data <= v;
        @(posedge i_sys_clk);
        i_wr_en <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_rd_en <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd_en <= 1'b0;
        #1 d = o_rd_data;
    endtask
    task irq_is(input logic e);
        repeat (4) @(posedge i_sys_clk);
        #1 chk("irq", {31'h0, o_irq}, {31'h0, e});
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_mirror;
        for (int k = 0; k < 11; k++)
        begin
            cmd <= 10'h1 << k;
            rd(OFS_STATUS);
            chk("status", d, {21'h0, cmd[9:8], 1'b0, cmd[7:0]});
        end
    endtask
    task t_status_ro;
        cmd <= 10'h2aa;
        wr(OFS_STATUS, 32'hffff_ffff);
        rd(OFS_STATUS);
        chk("status ro", d, 32'h0000_04aa);
        rd(8'h10);
        chk("unmapped", d, 32'h0);
    endtask
    task t_enable;
        cmd <= 10'h0;
        rd(OFS_ENABLE);
        chk("enable rst", d, RST_ENABLE);
        rd(OFS_EVENT);
        chk("event all", d, 32'h0000_06ff);
        wr(OFS_ENABLE, 32'hffff_ffff);
        rd(OFS_ENABLE);
        chk("enable", d, ENABLE_MASK);
        cmd <= 10'h0ff;
        irq_is(1'b0);
        cmd <= 10'h1ff;
        irq_is(1'b1);
        cmd <= 10'h0;
        rd(OFS_EVENT);
        chk("event", d, 32'h0000_02ff);
        irq_is(1'b0);
        wr(OFS_ENABLE, 32'h0);
        cmd <= 10'h200;
        irq_is(1'b0);
    endtask
    task t_event;
        wr(OFS_ENABLE, 32'h0000_0400);
        cmd <= 10'h0;
        rd(OFS_EVENT);
        chk("event masked", d, 32'h0000_0400);
        cmd <= 10'h200;
        rd(OFS_EVENT);
        chk("event in clear", d, 32'h0);
        cmd <= 10'h0;
        irq_is(1'b1);
        wr(OFS_EVENT, 32'h0);
        rd(OFS_EVENT);
        chk("event kept", d, 32'h0000_0400);
        irq_is(1'b0);
    endtask
    initial
    begin
        {i_nrst, i_wr_en, i_rd_en, i_addr, i_wr_data, cmd} = '0;
        repeat (10) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        t_mirror;
        t_status_ro;
        t_enable;
        t_event;
        end_sim;
    end
    initial
    begin
        #5000;
        miscompares++;
        end_sim;
    end
endmodule // testbench
